// ---- ncur_host.sv ----
// controller end: apb slave registers that drive the parallel port,
// with an automatic setup sequence after reset
// assumes: apb master on clk_i; device on the same clock
`timescale 1ns/1ps
module ncur_host (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ncur_port_if.host port
);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------

    wire sel_cfg;
    wire sel_cmd;
    wire sel_stat;
    wire mapped;
    wire access;
    wire wr_cfg;
    wire wr_cmd;
    assign sel_cfg = (paddr == ncur_pkg::APB_CFG);
    assign sel_cmd = (paddr == ncur_pkg::APB_CMD);
    assign sel_stat = (paddr == ncur_pkg::APB_STAT);
    assign mapped = sel_cfg | sel_cmd | sel_stat;
    // zero wait state slave
    assign pready = 1'b1;
    assign access = psel & penable;
    // unmapped address answers with an error
    assign pslverr = access & ~mapped;
    assign wr_cfg = access & pwrite & sel_cfg;
    assign wr_cmd = access & pwrite & sel_cmd;

    // ----------------------------------------------------------------
    // configuration and pending work
    // ----------------------------------------------------------------

    logic ser_en_reg;                // wanted serial path enable
    logic fb_en_reg;                 // wanted feedback enable
    logic tim_late_reg;              // 1 selects 11b, 0 selects 00b
    logic pend_tim_reg;              // timing_control write owed
    logic pend_osc_reg;              // oscillator_control write owed
    logic pend_pin_reg;              // update pulse on the pin owed
    logic pend_upd_reg;              // address 15 write owed
    logic init_done_reg;             // first timing write issued
    ncur_pkg::ncur_hstate_t state_reg; // sequencer state

    // next action in fixed order: timing, oscillator, pin, address 15
    wire idle;
    wire do_tim;
    wire do_osc;
    wire do_pin;
    wire do_upd;
    assign idle = (state_reg == ncur_pkg::HS_IDLE);
    assign do_tim = idle & pend_tim_reg;
    assign do_osc = idle & ~pend_tim_reg & pend_osc_reg;
    assign do_pin = idle & ~pend_tim_reg & ~pend_osc_reg & pend_pin_reg;
    assign do_upd = idle & ~pend_tim_reg & ~pend_osc_reg & ~pend_pin_reg & pend_upd_reg;

    // cfg write requests both register writes; set wins over clear
    wire pend_tim_next;
    wire pend_osc_next;
    wire pend_pin_next;
    wire pend_upd_next;
    assign pend_tim_next = wr_cfg | (pend_tim_reg & ~do_tim);
    assign pend_osc_next = wr_cfg | (pend_osc_reg & ~do_osc);
    assign pend_pin_next = (wr_cmd & pwdata[ncur_pkg::CMD_PIN_BIT]) | (pend_pin_reg & ~do_pin);
    assign pend_upd_next = (wr_cmd & pwdata[ncur_pkg::CMD_REG_BIT]) | (pend_upd_reg & ~do_upd);

    // config and pending flags; reset owes the setup writes and an update
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ser_en_reg <= 1'b0;
            fb_en_reg <= 1'b1;
            tim_late_reg <= 1'b0;
            pend_tim_reg <= 1'b1;
            pend_osc_reg <= 1'b1;
            pend_pin_reg <= 1'b1;
            pend_upd_reg <= 1'b0;
            init_done_reg <= 1'b0;
        end else begin
            if (wr_cfg) begin
                ser_en_reg <= pwdata[ncur_pkg::OSC_SER_BIT];
                fb_en_reg <= pwdata[ncur_pkg::OSC_FB_BIT];
                tim_late_reg <= pwdata[ncur_pkg::CFG_TIM_BIT];
            end
            pend_tim_reg <= pend_tim_next;
            pend_osc_reg <= pend_osc_next;
            pend_pin_reg <= pend_pin_next;
            pend_upd_reg <= pend_upd_next;
            init_done_reg <= init_done_reg | do_tim;
        end
    end

    // ----------------------------------------------------------------
    // port data
    // ----------------------------------------------------------------

    // reserved bits always the reset pattern
    wire [7:0] osc_data;
    assign osc_data = ncur_pkg::OSC_FIXED |
                      (8'(ser_en_reg) << ncur_pkg::OSC_SER_BIT) |
                      (8'(fb_en_reg) << ncur_pkg::OSC_FB_BIT);

    // only 00b or 11b, giving 00h or 30h
    wire [7:0] tim_data;
    assign tim_data = 8'({tim_late_reg ? ncur_pkg::TIM_LATE : ncur_pkg::TIM_EARLY})
                      << ncur_pkg::TIM_LO;

    // ----------------------------------------------------------------
    // port sequencer: one drive cycle, one release cycle
    // ----------------------------------------------------------------

    logic wr_reg;
    logic we_n_reg;
    logic update_n_reg;
    logic [3:0] addr_reg;
    logic [7:0] data_reg;

    // drives one action per two cycles
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ncur_pkg::HS_IDLE;
            wr_reg <= 1'b0;
            we_n_reg <= 1'b1;
            update_n_reg <= 1'b1;
            addr_reg <= 4'h0;
            data_reg <= 8'h00;
        end else begin
            case (state_reg)
                ncur_pkg::HS_IDLE: begin
                    // start the chosen action, if any
                    wr_reg <= do_tim | do_osc | do_upd;
                    we_n_reg <= ~(do_tim | do_osc | do_upd);
                    update_n_reg <= ~do_pin;
                    if (do_tim) begin
                        addr_reg <= ncur_pkg::ADDR_TIM;
                        data_reg <= tim_data;
                    end else if (do_osc) begin
                        addr_reg <= ncur_pkg::ADDR_OSC;
                        data_reg <= osc_data;
                    end else if (do_upd) begin
                        addr_reg <= ncur_pkg::ADDR_UPD;
                        data_reg <= 8'h00;
                    end
                    if (do_tim | do_osc | do_pin | do_upd) begin
                        state_reg <= ncur_pkg::HS_DRIVE;
                    end
                end
                ncur_pkg::HS_DRIVE: begin
                    // release strobes
                    wr_reg <= 1'b0;
                    we_n_reg <= 1'b1;
                    update_n_reg <= 1'b1;
                    state_reg <= ncur_pkg::HS_IDLE;
                end
                default: begin
                    state_reg <= ncur_pkg::HS_IDLE;
                end
            endcase
        end
    end

    assign port.wr = wr_reg;
    assign port.we_n = we_n_reg;
    assign port.update_n = update_n_reg;
    assign port.addr = addr_reg;
    assign port.data = data_reg;

    // ----------------------------------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------------------------------

    wire busy;
    wire [31:0] rd_mux;
    assign busy = ~idle | pend_tim_reg | pend_osc_reg | pend_pin_reg | pend_upd_reg;
    assign rd_mux = sel_cfg ? ((32'(ser_en_reg) << ncur_pkg::OSC_SER_BIT) |
                               (32'(fb_en_reg) << ncur_pkg::OSC_FB_BIT) |
                               (32'(tim_late_reg) << ncur_pkg::CFG_TIM_BIT)) :
                    sel_stat ? ((32'(busy) << ncur_pkg::STAT_BUSY_BIT) |
                                (32'(init_done_reg) << ncur_pkg::STAT_INIT_BIT)) :
                    32'h0;

    // read data register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata <= 32'h0;
        end else if (psel & ~penable) begin
            prdata <= rd_mux;
        end
    end

endmodule // ncur_host

// ---- ncur_pkg.sv ----
// constants shared by both ends of the oscillator control register port
// assumes: one 10 MHz clock, active-low asynchronous reset at both ends
package ncur_pkg;

    // ----------------------------------------------------------------
    // parallel write port geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;                      // register address width
    localparam int DATA_W = 8;                      // register data width
    localparam int FREQ_W = 48;                     // frequency sum width
    localparam int SER_W = 40;                      // serial tuning word width
    localparam int SER_SHIFT = FREQ_W - SER_W;      // serial word aligns to top

    // ----------------------------------------------------------------
    // device register addresses
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_OSC = 4'hd;         // oscillator_control
    localparam logic [3:0] ADDR_TIM = 4'he;         // timing_control
    localparam logic [3:0] ADDR_UPD = 4'hf;         // update_trigger, stores nothing

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int OSC_SER_BIT = 6;                 // serial path enable
    localparam int OSC_FB_BIT = 5;                  // accumulator feedback enable
    localparam int TIM_LO = 4;                      // capture timing low bit
    localparam int TIM_HI = 5;                      // capture timing high bit
    localparam logic [7:0] OSC_RST = 8'hf8;         // oscillator_control reset
    localparam logic [7:0] TIM_RST = 8'h10;         // timing_control reset
    localparam logic [7:0] OSC_FIXED = 8'h98;       // bit 7 and bits 4:0 pattern
    localparam logic [1:0] TIM_EARLY = 2'h0;        // capture setting 00b
    localparam logic [1:0] TIM_LATE = 2'h3;         // capture setting 11b

    // ----------------------------------------------------------------
    // controller registers on apb (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] APB_CFG = 8'h00;         // wanted field values
    localparam logic [7:0] APB_CMD = 8'h04;         // update commands
    localparam logic [7:0] APB_STAT = 8'h08;        // busy and init state
    localparam int CFG_TIM_BIT = 8;                 // cfg: 1 selects 11b timing
    localparam int CMD_PIN_BIT = 0;                 // cmd: update over the pin
    localparam int CMD_REG_BIT = 1;                 // cmd: update by address 15
    localparam int STAT_BUSY_BIT = 0;               // stat: work outstanding
    localparam int STAT_INIT_BIT = 1;               // stat: timing written

    // controller sequencer states
    typedef enum logic [0:0] {
        HS_IDLE = 1'b0,
        HS_DRIVE = 1'b1
    } ncur_hstate_t;

endpackage

// ---- ncur_port_if.sv ----
// the parallel write-only register port between controller and device
// assumes: both ends on the same clock; the host drives, the device listens
`timescale 1ns/1ps
interface ncur_port_if;
    logic wr;                   // write strobe, one-cycle pulse
    logic we_n;                 // write enable, active low with wr
    logic [3:0] addr;           // register address
    logic [7:0] data;           // write data
    logic update_n;             // update pin, active low one-cycle pulse

    // controller end drives every line
    modport host (output wr, output we_n, output addr, output data, output update_n);
    // device end only listens
    modport device (input wr, input we_n, input addr, input data, input update_n);
endinterface // ncur_port_if

// ---- ncur_device.sv ----
// device end: master and active copies of
// oscillator_control and timing_control,
// the address-15 update trigger, and the
// frequency sum and phase accumulator they steer
// assumes: port driven by logic on clk_i, so no synchronisers are needed
`timescale 1ns/1ps

// Summary of operation
// - bit 6 gates serial term into sum
// - gating leaves stored serial word untouched
// - software clears serial enable when unused
// - bit 5 enables accumulator feedback
// - reserved low bits keep reset pattern
// - software writes 00h or 30h after reset
// - timing bits 5:4 only 11b or 00b
// - write to address 15 acts as update
module ncur_device (
    input wire logic clk_i,
    input wire logic rstn_i,
    ncur_port_if.device port,
    input wire logic [47:0] cf_term_i,
    input wire logic [47:0] of_term_i,
    input wire logic [39:0] sf_word_i,
    output logic [47:0] freq_sum_o,
    output logic [47:0] phase_o,
    output logic feedback_en_o,
    output logic serial_en_o,
    output logic [1:0] dac_timing_o,
    output logic timing_invalid_o,
    output logic update_o
);

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------

    // a port write is a strobe with enable low
    wire write_hit;
    assign write_hit = port.wr & ~port.we_n;

    // write to one given address
    function automatic logic hit_at(input logic [3:0] want);
        hit_at = write_hit & (port.addr == want);
    endfunction

    // one select per address that this block owns
    wire wr_osc;
    wire wr_tim;
    wire wr_upd;
    assign wr_osc = hit_at(ncur_pkg::ADDR_OSC);
    assign wr_tim = hit_at(ncur_pkg::ADDR_TIM);
    assign wr_upd = hit_at(ncur_pkg::ADDR_UPD);

    // pin or address 15 give the same event
    wire update_evt;
    assign update_evt = ~port.update_n | wr_upd;

    // ----------------------------------------------------------------
    // master registers
    // ----------------------------------------------------------------

    logic [7:0] osc_master_reg;      // oscillator_control as last written
    logic [7:0] osc_master_next;     // next master value
    logic [7:0] tim_master_reg;      // timing_control as last written
    logic [7:0] tim_master_next;     // next master value

    // masters take port data;
    // the update address stores nothing
    assign osc_master_next = wr_osc ? port.data : osc_master_reg;
    assign tim_master_next = wr_tim ? port.data : tim_master_reg;

    // master store, reset to the power-on patterns
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_master_reg <= ncur_pkg::OSC_RST;
            tim_master_reg <= ncur_pkg::TIM_RST;
        end else begin
            osc_master_reg <= osc_master_next;
            tim_master_reg <= tim_master_next;
        end
    end

    // ----------------------------------------------------------------
    // active registers
    // ----------------------------------------------------------------

    logic [7:0] osc_active_reg;      // oscillator_control seen by datapath
    logic [7:0] osc_active_next;     // next active value
    logic [7:0] tim_active_reg;      // timing_control seen by datapath
    logic [7:0] tim_active_next;     // next active value

    assign osc_active_next = update_evt ? osc_master_reg : osc_active_reg;
    assign tim_active_next = update_evt ? tim_master_reg : tim_active_reg;

    // active store; a write and an update in one cycle
    // transfer the old master
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_active_reg <= ncur_pkg::OSC_RST;
            tim_active_reg <= ncur_pkg::TIM_RST;
        end else begin
            osc_active_reg <= osc_active_next;
            tim_active_reg <= tim_active_next;
        end
    end

    // ----------------------------------------------------------------
    // field extraction
    // ----------------------------------------------------------------

    wire ser_en;
    assign ser_en = osc_active_reg[ncur_pkg::OSC_SER_BIT];

    wire fb_en;
    assign fb_en = osc_active_reg[ncur_pkg::OSC_FB_BIT];

    wire [1:0] tim_field;
    assign tim_field = tim_active_reg[ncur_pkg::TIM_HI:ncur_pkg::TIM_LO];

    // only 00b and 11b are operating settings
    wire tim_bad;
    assign tim_bad = (tim_field != ncur_pkg::TIM_EARLY) &
                     (tim_field != ncur_pkg::TIM_LATE);

    // ----------------------------------------------------------------
    // frequency sum
    // ----------------------------------------------------------------

    // serial word placed on the upper bits of the sum
    wire [47:0] sf_aligned;
    assign sf_aligned = {sf_word_i, {ncur_pkg::SER_SHIFT{1'b0}}};

    // only the contribution is zeroed
    // sf_word_i is read, never altered
    // gate serial term
    wire [47:0] sf_gated;
    assign sf_gated = ser_en ? sf_aligned : 48'h0;

    // modulo 2^48 add, carry out dropped
    function automatic logic [47:0] add48(
        input logic [47:0] a,
        input logic [47:0] b
    );
        add48 = 48'(a + b);
    endfunction

    // three terms added modulo 2^48
    wire [47:0] sum_next;
    assign sum_next = add48(add48(cf_term_i, of_term_i), sf_gated);

    // ----------------------------------------------------------------
    // phase accumulator
    // ----------------------------------------------------------------

    logic [47:0] sum_reg;            // registered frequency sum
    logic [47:0] phase_reg;          // accumulated phase
    logic [47:0] phase_next;         // next phase

    // feedback off: phase follows the sum
    assign phase_next = fb_en ? add48(phase_reg, sum_reg) : sum_reg;

    // sum and phase pipeline
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sum_reg <= 48'h0;
            phase_reg <= 48'h0;
        end else begin
            sum_reg <= sum_next;
            phase_reg <= phase_next;
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------

    logic update_reg;                // update seen last cycle
    logic tim_bad_reg;               // timing setting not valid

    // flags registered so every data output
    // comes from a flop
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            update_reg <= 1'b0;
            tim_bad_reg <= 1'b1;
        end else begin
            update_reg <= update_evt;
            tim_bad_reg <= tim_bad;
        end
    end

    // outputs
    assign freq_sum_o = sum_reg;
    assign phase_o = phase_reg;
    assign feedback_en_o = fb_en;
    assign serial_en_o = ser_en;
    assign dac_timing_o = tim_field;
    assign timing_invalid_o = tim_bad_reg;
    assign update_o = update_reg;

endmodule // ncur_device

// ---- ncur_chk.sv ----
// checker for the parallel register port and the device outputs it steers
// assumes: one clock, active-low asynchronous reset, instantiated beside the port
`timescale 1ns/1ps
module ncur_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wr,
    input wire logic we_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] data,
    input wire logic update_n,
    input wire logic [47:0] cf_term_i,
    input wire logic [47:0] of_term_i,
    input wire logic [39:0] sf_word_i,
    input wire logic [47:0] freq_sum_o,
    input wire logic feedback_en_o,
    input wire logic serial_en_o,
    input wire logic [1:0] dac_timing_o,
    input wire logic timing_invalid_o,
    input wire logic update_o
);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    wire wr_ok = wr && !we_n; // a write the device takes
    wire upd_evt = !update_n || (wr_ok && addr == ncur_pkg::ADDR_UPD); // pin or address 15
    wire [47:0] sum_exp = cf_term_i + of_term_i + (serial_en_o ? {sf_word_i, 8'h00} : 48'h0);
    logic [7:0] osc_m_reg; // shadow of the oscillator master copy
    logic [7:0] tim_m_reg; // shadow of the timing master copy
    // shadow masters follow the port writes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_m_reg <= ncur_pkg::OSC_RST;
            tim_m_reg <= ncur_pkg::TIM_RST;
        end else if (wr_ok && addr == ncur_pkg::ADDR_OSC) begin
            osc_m_reg <= data;
        end else if (wr_ok && addr == ncur_pkg::ADDR_TIM) begin
            tim_m_reg <= data;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_ser_follow; upd_evt |=> serial_en_o == $past(osc_m_reg[6]); endproperty
    property p_fb_follow; upd_evt |=> feedback_en_o == $past(osc_m_reg[5]); endproperty
    property p_tim_follow; upd_evt |=> dac_timing_o == $past(tim_m_reg[5:4]); endproperty
    property p_ser_hold; $changed(serial_en_o) |-> $past(upd_evt); endproperty
    property p_upd_pulse; upd_evt |=> update_o; endproperty
    property p_upd_cause; update_o |-> $past(upd_evt); endproperty
    property p_tinv; $past(rstn_i) |-> timing_invalid_o == !($past(dac_timing_o) inside {2'h0, 2'h3});
    endproperty
    property p_sum; $past(rstn_i) |-> freq_sum_o == $past(sum_exp); endproperty
    property p_osc_fixed; wr_ok && addr == ncur_pkg::ADDR_OSC |-> (data & 8'h9f) == ncur_pkg::OSC_FIXED;
    endproperty
    property p_tim_legal; wr_ok && addr == ncur_pkg::ADDR_TIM |-> data inside {8'h00, 8'h30};
    endproperty
    a_ser_follow: assert property (p_ser_follow) else $error("serial enable not copied");
    a_fb_follow: assert property (p_fb_follow) else $error("feedback enable not copied");
    a_tim_follow: assert property (p_tim_follow) else $error("timing field not copied");
    a_ser_hold: assert property (p_ser_hold) else $error("serial enable moved alone");
    a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse missing");
    a_upd_cause: assert property (p_upd_cause) else $error("update pulse without cause");
    a_tinv: assert property (p_tinv) else $error("timing invalid flag wrong");
    a_sum: assert property (p_sum) else $error("frequency sum wrong");
    a_osc_fixed: assert property (p_osc_fixed) else $error("reserved bits changed");
    a_tim_legal: assert property (p_tim_legal) else $error("illegal timing write");
    c_pin: cover property (!update_n);
    c_addr: cover property (wr_ok && addr == ncur_pkg::ADDR_UPD);
    c_ser_on: cover property (wr_ok && addr == ncur_pkg::ADDR_OSC && data[6]);
endmodule // ncur_chk

// ---- nco_control_update_regs_tb.sv ----
// testbench: apb host drives the device through the shared port
// assumes: package, interface, both ends and checker compiled first
`timescale 1ns/1ps
module nco_control_update_regs_tb;
    logic clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se;
    logic [47:0] cf = 48'h1000, of = 48'h20, freq_sum_o, phase_o, ph0;
    logic [39:0] sf = 40'h3;
    logic feedback_en_o, serial_en_o, timing_invalid_o, update_o;
    logic [1:0] dac_timing_o;
    int err_total = 0, total_checks = 0;
    // 10 MHz clock
    always #50 clk_i = ~clk_i;
    ncur_port_if u_ncur_port_if();
    ncur_host u_ncur_host (.clk_i(clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port(u_ncur_port_if.host));
    ncur_device u_ncur_device (.clk_i(clk_i), .rstn_i(rstn_i), .port(u_ncur_port_if.device),
        .cf_term_i(cf), .of_term_i(of), .sf_word_i(sf), .freq_sum_o(freq_sum_o),
        .phase_o(phase_o), .feedback_en_o(feedback_en_o), .serial_en_o(serial_en_o),
        .dac_timing_o(dac_timing_o), .timing_invalid_o(timing_invalid_o), .update_o(update_o));
    ncur_chk u_ncur_chk (.clk_i(clk_i), .rstn_i(rstn_i), .wr(u_ncur_port_if.wr),
        .we_n(u_ncur_port_if.we_n), .addr(u_ncur_port_if.addr), .data(u_ncur_port_if.data),
        .update_n(u_ncur_port_if.update_n), .cf_term_i(cf), .of_term_i(of), .sf_word_i(sf),
        .freq_sum_o(freq_sum_o), .feedback_en_o(feedback_en_o), .serial_en_o(serial_en_o),
        .dac_timing_o(dac_timing_o), .timing_invalid_o(timing_invalid_o), .update_o(update_o));
    // ----------------------------------------------------------------
    // verdict and helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin err_total++; complete_run(); end
    endtask
    // wait until the host has sent everything queued
    task automatic wait_idle();
        int n;
        for (n = 0; n < 40; n++) begin
            apb(1'b0, ncur_pkg::APB_STAT, 32'h0);
            if (rd[ncur_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n >= 40) begin err_total++; complete_run(); end
    endtask
    // ask for an update and wait for its pulse
    task automatic do_upd(input logic [31:0] cmd);
        int n;
        apb(1'b1, ncur_pkg::APB_CMD, cmd);
        for (n = 0; n < 40 && update_o !== 1'b1; n++) @(posedge clk_i);
        if (n >= 40) begin err_total++; complete_run(); end
        repeat (3) @(posedge clk_i);
    endtask
    // check the active copies
    task automatic chk_act(input logic s, input logic f, input logic [1:0] t);
        chk("serial_en_o", {47'h0, s}, {47'h0, serial_en_o});
        chk("feedback_en_o", {47'h0, f}, {47'h0, feedback_en_o});
        chk("dac_timing_o", {46'h0, t}, {46'h0, dac_timing_o});
        chk("freq_sum_o", cf + of + (s ? {sf, 8'h00} : 48'h0), freq_sum_o);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk_act(1'b1, 1'b1, 2'h1);
        chk("timing_invalid_o", 48'h1, {47'h0, timing_invalid_o});
        repeat (8) @(posedge clk_i);
        chk_act(1'b0, 1'b1, ncur_pkg::TIM_EARLY);
        chk("timing_invalid_o", 48'h0, {47'h0, timing_invalid_o});
        apb(1'b0, ncur_pkg::APB_STAT, 32'h0);
        chk("stat_init", 48'h1, {47'h0, rd[ncur_pkg::STAT_INIT_BIT]});
        $display("test reset done");
        // masters change, actives wait for the update
        apb(1'b1, ncur_pkg::APB_CFG, 32'h160);
        wait_idle();
        chk_act(1'b0, 1'b1, ncur_pkg::TIM_EARLY);
        do_upd(32'h1);
        chk_act(1'b1, 1'b1, ncur_pkg::TIM_LATE);
        $display("test pin update done");
        // serial path and feedback off, update by address 15
        apb(1'b1, ncur_pkg::APB_CFG, 32'h000);
        wait_idle();
        do_upd(32'h2);
        chk_act(1'b0, 1'b0, ncur_pkg::TIM_EARLY);
        ph0 = phase_o;
        repeat (4) @(posedge clk_i);
        chk("phase_hold", ph0, phase_o);
        // serial path back on: stored word returns untouched
        apb(1'b1, ncur_pkg::APB_CFG, 32'h060);
        wait_idle();
        do_upd(32'h2);
        chk_act(1'b1, 1'b1, ncur_pkg::TIM_EARLY);
        ph0 = phase_o;
        @(posedge clk_i);
        total_checks++;
        if (phase_o === ph0) begin
            err_total++;
            $display("wrong value phase_run expected change seen %h", phase_o);
        end
        $display("test address update done");
        // unmapped address is refused
        apb(1'b0, 8'h0c, 32'h0);
        chk("pslverr", 48'h1, {47'h0, se});
        chk("unmapped_read", 48'h0, {16'h0, rd});
        $display("test unmapped done");
        complete_run();
    end
endmodule // nco_control_update_regs_tb
